// file: logic/cascade_sync_regs.svh
/*
  register offsets, field positions, reset values and clock figures of the cascade
  channel synchronizer; assumes a 32-bit AXI4-Lite register window, one word each.
*/
`ifndef CASCADE_SYNC_REGS_SVH
`define CASCADE_SYNC_REGS_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define MODE_REGISTER_OFFSET 12'h000
`define STATUS_OFFSET 12'h004
`define MASK_OFFSET 12'h008
`define STATE_OFFSET 12'h00c
`define CASCADE_ENABLE_BIT 0
`define SYNC_ERROR_BIT 0
`define BUFFER_SLIP_BIT 1
`define MODE_REGISTER_RESET 32'h0000_0000
`define MASK_RESET 32'h0000_0000
// ----------------------------------------
// clocks
// ----------------------------------------
`define SYS_CLK_MHZ 200
`define BYTE_CLK_KHZ 12500
`endif

// file: logic/cascade_sync_pkg.sv
/*
  types of the cascade channel synchronizer; assumes nothing beyond the header.
*/
package cascade_sync_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ARMED = 5'b00010,
    ST_WAIT1 = 5'b00100,
    ST_WAIT2 = 5'b01000,
    ST_DATA = 5'b10000
  } sync_state_t;
  typedef logic [1:0] axi_resp_t;
  localparam axi_resp_t RESP_OKAY = 2'b00;
  localparam axi_resp_t RESP_SLVERR = 2'b10;
endpackage

// file: logic/cascade_channel_sync.sv
/*
  receive-side cascade synchronizer of one channel: aligns its byte stream to the
  group by the ready / aligned lines and delivers pairs to the host receive port.
  assumes byte clock, symbol pins and aligned line come from outside clk's domain
  and that the byte clock is far slower than clk.
*/
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "cascade_sync_regs.svh"
module cascade_channel_sync #(
  parameter int EB_DEPTH = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output cascade_sync_pkg::axi_resp_t s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [11:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output cascade_sync_pkg::axi_resp_t s_axi_rresp,
  input wire logic local_byte_clk,
  input wire logic [7:0] line_symbol_input,
  input wire logic line_jk_input,
  input wire logic line_end_input,
  input wire logic all_aligned_input,
  output logic cascade_ready_line_out,
  output logic cascade_ready_line_oe,
  output logic [7:0] host_pair_data,
  output logic host_pair_jk,
  output logic host_pair_valid,
  output logic irq
);
  import cascade_sync_pkg::*;
  localparam int PW = $clog2(EB_DEPTH);
  generate
    if (EB_DEPTH < 4 || (EB_DEPTH & (EB_DEPTH - 1)) != 0) begin : g_chk
      $error("EB_DEPTH must be a power of two of at least 4");
    end
  endgenerate
  // ----------------------------------------
  // pin synchronizers
  // ----------------------------------------
  logic [2:0] lbc_q, aln_q, jk_q, end_q;
  logic [7:0] sym0_q, sym1_q, sym2_q;
  logic lbc_lvl_q, aln_lvl_q;
  logic rise, fall;
  always_ff @(posedge clk) begin
    lbc_q <= {lbc_q[1:0], local_byte_clk};
    aln_q <= {aln_q[1:0], all_aligned_input};
    jk_q <= {jk_q[1:0], line_jk_input};
    end_q <= {end_q[1:0], line_end_input};
    sym0_q <= line_symbol_input;
    sym1_q <= sym0_q;
    sym2_q <= sym1_q;
  end
  // a change counts only once the last two stages agree; glitches are dropped
  assign rise = (lbc_q[1] == lbc_q[2]) && lbc_q[2] && !lbc_lvl_q;
  assign fall = (lbc_q[1] == lbc_q[2]) && !lbc_q[2] && lbc_lvl_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      lbc_lvl_q <= 1'b0;
      aln_lvl_q <= 1'b0;
    end else begin
      if (lbc_q[1] == lbc_q[2]) lbc_lvl_q <= lbc_q[2];
      if (aln_q[1] == aln_q[2]) aln_lvl_q <= aln_q[2];
    end
  end
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [31:0] mode_q, mask_q;
  logic [1:0] status_q;
  logic cascade_en;
  logic err_set, slip_set;
  logic aw_got_q, w_got_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic wr_go;
  logic [1:0] w1c;
  assign cascade_en = mode_q[`CASCADE_ENABLE_BIT];
  assign wr_go = aw_got_q && w_got_q && !s_axi_bvalid;
  assign w1c = (wr_go && awaddr_q == `STATUS_OFFSET) ? wdata_q[1:0] : 2'b00;
  always_ff @(posedge clk) begin
    if (reset) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
      end
      if (wr_go) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q > `STATE_OFFSET || awaddr_q[1:0] != 2'b00) ?
                       RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk) begin
    s_axi_awready <= !reset && !aw_got_q && !(s_axi_awvalid && s_axi_awready);
    s_axi_wready <= !reset && !w_got_q && !(s_axi_wvalid && s_axi_wready);
    s_axi_arready <= !reset && !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
  end
  // only the low byte lane holds fields, so only wstrb[0] is honoured
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_q <= `MODE_REGISTER_RESET;
      mask_q <= `MASK_RESET;
    end else if (wr_go && awaddr_q == `MODE_REGISTER_OFFSET) begin
      mode_q <= {31'h0000_0000, wdata_q[`CASCADE_ENABLE_BIT]};
    end else if (wr_go && awaddr_q == `MASK_OFFSET) begin
      mask_q <= {30'h0000_0000, wdata_q[1:0]};
    end
  end
  // set beats clear so an error in the clearing cycle is kept
  always_ff @(posedge clk) begin
    if (reset) begin
      status_q <= 2'b00;
      irq <= 1'b0;
    end else begin
      status_q <= (status_q & ~w1c) | {slip_set, err_set};
      irq <= |(status_q & mask_q[1:0]);
    end
  end
  // ----------------------------------------
  // alignment state machine
  // ----------------------------------------
  sync_state_t state_q;
  logic released_q, jk2_q;
  logic [8:0] eb_mem [EB_DEPTH];
  logic [PW-1:0] wr_ptr_q, rd_ptr_q;
  logic [8:0] eb_head;
  assign eb_head = eb_mem[rd_ptr_q];
  assign err_set = cascade_en && state_q == ST_WAIT2 && fall && !aln_lvl_q;
  assign slip_set = rise && state_q != ST_IDLE && (wr_ptr_q + PW'(1)) == rd_ptr_q;
  always_ff @(posedge clk) begin
    if (reset || !cascade_en) begin
      state_q <= ST_IDLE;
      released_q <= 1'b0;
      jk2_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          released_q <= 1'b0;
          jk2_q <= 1'b0;
          if (rise && jk_q[2]) state_q <= ST_ARMED;
        end
        ST_ARMED: begin
          if (fall) begin
            released_q <= 1'b1;
            state_q <= ST_WAIT1;
          end
        end
        ST_WAIT1: begin
          if (fall && aln_lvl_q) state_q <= ST_DATA;
          else if (fall) begin
            state_q <= ST_WAIT2;
            jk2_q <= 1'b1;
          end
        end
        ST_WAIT2: begin
          if (fall) state_q <= ST_DATA;
        end
        ST_DATA: begin
          if (rise && eb_head[8]) state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
  // the buffer soaks up the bytes that arrive while the group is still aligning
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else if (rise && state_q == ST_IDLE) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else if (rise) begin
      eb_mem[wr_ptr_q] <= {end_q[2], sym2_q};
      wr_ptr_q <= wr_ptr_q + PW'(1);
      if (state_q == ST_DATA) rd_ptr_q <= rd_ptr_q + PW'(1);
    end
  end
  // ----------------------------------------
  // host receive port and ready line
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      host_pair_data <= 8'h00;
      host_pair_jk <= 1'b0;
      host_pair_valid <= 1'b0;
    end else if (rise) begin
      if (!cascade_en || state_q == ST_IDLE) begin
        host_pair_data <= sym2_q;
        host_pair_jk <= jk_q[2];
        host_pair_valid <= 1'b1;
      end else if (state_q == ST_DATA) begin
        host_pair_data <= eb_head[7:0];
        host_pair_jk <= 1'b0;
        host_pair_valid <= 1'b1;
      end else begin
        host_pair_data <= 8'h00;
        host_pair_jk <= jk2_q;
        host_pair_valid <= jk2_q;
      end
    end
  end
  // open drain: the pin is pulled low while held, let go when released
  always_ff @(posedge clk) begin
    if (reset) begin
      cascade_ready_line_out <= 1'b0;
      cascade_ready_line_oe <= 1'b1;
    end else begin
      cascade_ready_line_out <= 1'b0;
      cascade_ready_line_oe <= !released_q;
    end
  end
  // ----------------------------------------
  // readback
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr)
        `MODE_REGISTER_OFFSET: s_axi_rdata <= mode_q;
        `STATUS_OFFSET: s_axi_rdata <= {30'h0000_0000, status_q};
        `MASK_OFFSET: s_axi_rdata <= mask_q;
        `STATE_OFFSET: s_axi_rdata <= {25'h0000000, aln_lvl_q, released_q, state_q};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  ready_release_a: assert property (state_q == ST_ARMED && fall
    |=> ##1 !cascade_ready_line_oe)
    else $error("ready line not released after jk");
  host_edge_a: assert property (!rise |=> $stable({host_pair_data, host_pair_valid}))
    else $error("host port moved off a byte clock rise");
  second_jk_a: assert property (state_q == ST_WAIT1 && fall && !aln_lvl_q && cascade_en
    |=> state_q == ST_WAIT2 && jk2_q)
    else $error("missing second jk");
  single_jk_a: assert property (state_q == ST_WAIT1 && fall && aln_lvl_q && cascade_en
    |=> state_q == ST_DATA && !jk2_q)
    else $error("extra jk on early alignment");
  first_byte_a: assert property (state_q == ST_DATA && rise && rd_ptr_q == '0
    && cascade_en |=> host_pair_valid && !host_pair_jk && host_pair_data == $past(eb_mem[0][7:0]))
    else $error("first byte after jk not delivered");
  sync_error_a: assert property (err_set
    |=> status_q[`SYNC_ERROR_BIT] && state_q == ST_DATA)
    else $error("sync error not flagged");
  mode_gate_a: assert property (!cascade_en |=> state_q == ST_IDLE)
    else $error("alignment active with cascade mode off");
  hold_ready_a: assert property (state_q == ST_IDLE |=> ##1 cascade_ready_line_oe)
    else $error("ready line released between frames");
  frame_end_a: assert property (state_q == ST_DATA && rise && eb_head[8] && cascade_en
    |=> state_q == ST_IDLE)
    else $error("frame end not returning to idle");
  sticky_err_a: assert property (status_q[0] && !w1c[0] |=> status_q[0])
    else $error("sync error flag lost");
  one_jk_c: cover property (state_q == ST_WAIT1 && fall && aln_lvl_q);
  two_jk_c: cover property (state_q == ST_WAIT2 && fall && aln_lvl_q);
  error_c: cover property (err_set);
  clear_c: cover property (status_q[0] ##1 !status_q[0]);
endmodule

// file: tb/sibling_link_model.sv
/*
  far side of one channel: free byte clock, framed symbol source, sibling
  ready lines and their wired-AND; assumes everything runs on clk by NBA.
*/
`timescale 1ns/1ps
module sibling_link_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic go,
  input wire logic [7:0] sib_delay,
  input wire logic cascade_ready_line_out,
  input wire logic cascade_ready_line_oe,
  output logic local_byte_clk,
  output logic [7:0] line_symbol_input,
  output logic line_jk_input,
  output logic line_end_input,
  output logic all_aligned_input,
  output logic busy
);
  logic [2:0] div_q;
  logic [2:0] idx_q;
  logic [7:0] wait_q;
  logic sib_q;
  logic own_level;
  // ----
  // byte clock, 16 clk a period, free running
  // ----
  always_ff @(posedge clk) begin
    if (reset) begin
      div_q <= 3'h0;
      local_byte_clk <= 1'b0;
    end else begin
      div_q <= div_q + 3'h1;
      if (div_q == 3'h7) begin
        local_byte_clk <= ~local_byte_clk;
      end
    end
  end
  // ----
  // frame: jk, four bytes, last marked end; symbols move with the rise
  // ----
  always_ff @(posedge clk) begin
    if (reset) begin
      idx_q <= 3'h0;
      line_symbol_input <= 8'h00;
      line_jk_input <= 1'b0;
      line_end_input <= 1'b0;
    end else if (div_q == 3'h7 && !local_byte_clk) begin
      line_jk_input <= (idx_q == 3'h0) && go;
      line_end_input <= (idx_q == 3'h4);
      if (idx_q == 3'h0) begin
        line_symbol_input <= go ? 8'hc5 : 8'h00;
        idx_q <= {2'b00, go};
      end else begin
        line_symbol_input <= (idx_q == 3'h5) ? 8'h00 : 8'h0f + {5'h00, idx_q};
        idx_q <= (idx_q == 3'h5) ? 3'h0 : idx_q + 3'h1;
      end
    end
  end
  assign busy = (idx_q != 3'h0);
  // ----
  // siblings release sib_delay cycles after us; 8'hff means one never does
  // ----
  assign own_level = cascade_ready_line_oe ? cascade_ready_line_out : 1'b1;
  always_ff @(posedge clk) begin
    if (reset || cascade_ready_line_oe) begin
      wait_q <= 8'h00;
      sib_q <= 1'b0;
    end else if (sib_delay != 8'hff && wait_q >= sib_delay) begin
      sib_q <= 1'b1;
    end else begin
      wait_q <= wait_q + 8'h01;
    end
  end
  assign all_aligned_input = own_level && sib_q;
endmodule

// file: tb/cascade_channel_sync_test.sv
/*
  self-checking bench of the cascade synchronizer: axi-lite tasks and frames
  from the sibling model; assumes the design's register map header.
*/
`timescale 1ns/1ps
`include "cascade_sync_regs.svh"
module cascade_channel_sync_test;
  import cascade_sync_pkg::*;
  logic clk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, local_byte_clk;
  logic line_jk_input, line_end_input, all_aligned_input, cascade_ready_line_out;
  logic cascade_ready_line_oe, host_pair_jk, host_pair_valid, irq, go, busy, bclk_p, oe_p, oe_low;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [7:0] line_symbol_input, host_pair_data, sib_delay;
  axi_resp_t s_axi_bresp, s_axi_rresp;
  logic [8:0] seen_q[$];
  int fail_count, comparisons;
  cascade_channel_sync u_cascade_channel_sync (.clk, .reset, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .local_byte_clk, .line_symbol_input,
    .line_jk_input, .line_end_input, .all_aligned_input, .cascade_ready_line_out,
    .cascade_ready_line_oe, .host_pair_data, .host_pair_jk, .host_pair_valid, .irq);
  sibling_link_model u_sibling_link_model (.clk, .reset, .go, .sib_delay, .cascade_ready_line_out,
    .cascade_ready_line_oe, .local_byte_clk, .line_symbol_input, .line_jk_input,
    .line_end_input, .all_aligned_input, .busy);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ----
  // checking and closing
  // ----
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic timeout();
    fail_count++;
    close_out();
  endtask
  // ----
  // bus tasks: ready is looked at just before the edge that takes it
  // ----
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input axi_resp_t er);
    logic at, wt;
    int n;
    at = 1'b0;
    wt = 1'b0;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(at && wt)) begin
      @(negedge clk);
      at = at | (s_axi_awvalid & s_axi_awready);
      wt = wt | (s_axi_wvalid & s_axi_wready);
      if (++n > 200) timeout();
      @(posedge clk);
      if (at) s_axi_awvalid <= 1'b0;
      if (wt) s_axi_wvalid <= 1'b0;
    end
    do begin
      @(negedge clk);
      if (++n > 400) timeout();
    end while (s_axi_bvalid !== 1'b1);
    chk("bresp", s_axi_bresp, er);
    @(posedge clk);
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic axr(input logic [11:0] a, input logic [31:0] ed, input axi_resp_t er,
                     input string what);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clk);
      if (++n > 200) timeout();
    end while (s_axi_arready !== 1'b1);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) begin
      @(negedge clk);
      if (++n > 400) timeout();
    end
    chk(what, s_axi_rdata, ed);
    chk("rresp", s_axi_rresp, er);
    @(posedge clk);
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask
  // ----
  // host pairs are taken at each byte clock fall, idles skipped
  // ----
  always @(posedge clk) begin
    bclk_p <= local_byte_clk;
    oe_p <= cascade_ready_line_oe;
    if (bclk_p && !local_byte_clk && host_pair_valid === 1'b1 &&
        {host_pair_jk, host_pair_data} != 9'h0)
      seen_q.push_back({host_pair_jk, host_pair_data});
    if (oe_p === 1'b1 && cascade_ready_line_oe === 1'b0) begin
      oe_low = 1'b1;
      chk("release phase", local_byte_clk, 1'b0);
    end
  end
  task automatic frame(input logic [7:0] dly, input int njk, input logic [31:0] err);
    int n;
    logic [31:0] ex;
    n = 0;
    seen_q.delete();
    oe_low = 1'b0;
    sib_delay <= dly;
    go <= 1'b1;
    while (busy !== 1'b1 && ++n < 300) @(posedge clk);
    if (n >= 300) timeout();
    go <= 1'b0;
    while (busy !== 1'b0 && ++n < 600) @(posedge clk);
    if (n >= 600) timeout();
    // ten byte periods let the buffered bytes drain
    repeat (160) @(posedge clk);
    chk("pair count", seen_q.size(), njk + 4);
    for (int i = 0; i < seen_q.size(); i++) begin
      // a repeated jk is told by its mark alone, its symbol byte reads zero
      ex = (i == 0) ? 32'h1c5 : (i < njk) ? 32'h100 : 32'h10 + i - njk;
      chk("pair", seen_q[i], ex);
    end
    chk("held between", cascade_ready_line_oe, 1'b1);
    chk("ready level", cascade_ready_line_out, 1'b0);
    axr(`STATUS_OFFSET, err, RESP_OKAY, "status");
  endtask
  initial begin
    {reset, go, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h7f;
    {go, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, sib_delay} = 64'h0;
    s_axi_wstrb = 4'hf;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk("oe reset", cascade_ready_line_oe, 1'b1);
    chk("irq reset", irq, 1'b0);
    axr(`MODE_REGISTER_OFFSET, `MODE_REGISTER_RESET, RESP_OKAY, "mode");
    axr(`MASK_OFFSET, `MASK_RESET, RESP_OKAY, "mask");
    axr(`STATE_OFFSET, 32'h0000_0001, RESP_OKAY, "state");
    axr(12'h010, 32'h0, RESP_SLVERR, "unmapped");
    axw(12'h010, 32'h1, RESP_SLVERR);
    frame(8'h04, 1, 32'h0);
    chk("held when off", oe_low, 1'b0);
    axw(`MODE_REGISTER_OFFSET, 32'h1, RESP_OKAY);
    axw(`MASK_OFFSET, 32'h1, RESP_OKAY);
    frame(8'h02, 1, 32'h0);
    chk("released", oe_low, 1'b1);
    frame(8'h10, 2, 32'h0);
    chk("irq quiet", irq, 1'b0);
    frame(8'hff, 2, 32'h1);
    chk("irq set", irq, 1'b1);
    axr(`STATUS_OFFSET, 32'h1, RESP_OKAY, "status kept");
    axw(`MASK_OFFSET, 32'h0, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk("irq masked", irq, 1'b0);
    axw(`STATUS_OFFSET, 32'h1, RESP_OKAY);
    axr(`STATUS_OFFSET, 32'h0, RESP_OKAY, "status cleared");
    close_out();
  end
endmodule
